// ==== src/ipb_prio_bank.sv ====
// Notes on behaviour
// RQ1: Field value 111 gives level 7, the highest.
// RQ2: Field value 000 disables the source; it never requests service.
// RQ3: Value 001 gives level 1, lowest enabled; other codes map directly.
// RQ4: Unimplemented bits ignore writes and read as zero.
// RQ5: Every field resets to 100.
// RQ6: Register 8: CAN event at 14:12, CAN receive at 10:8.
// RQ7: Register 8: second SPI event at 6:4, SPI error at 2:0.
// RQ8: Register 9: capture 5 at 14:12, capture 4 at 10:8.
// RQ9: Register 9: capture 3 at 6:4, DMA 3 done at 2:0.
// RQ10: Register 10: compare 7 at 14:12, compare 6 at 10:8.
// RQ11: Register 10: compare 5 at 6:4, capture 6 at 2:0.
// RQ12: Register 11: timer 6 at 14:12, DMA 4 done at 10:8.
// RQ13: Register 11: only 2:0 low byte, compare 8; bits 7:3 read zero.
// RQ14: Register 12: timer 8 at 14:12, second I2C master at 10:8.
// RQ15: Register 12: second I2C slave at 6:4, timer 7 at 2:0.
// RQ16: Fields read back last write, effective at the next edge.
// RQ17: Every field level is presented continuously to arbitration.
//
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
module ipb_prio_bank
	import ipb_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [DATA_W-1:0] avs_writedata_i,
	input wire logic [DATA_W/BYTE_W-1:0] avs_byteenable_i,
	output logic [DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [NUM_FIELDS-1:0] src_pending_i,
	output logic [NUM_FIELDS-1:0] src_request_o,
	output logic [NUM_FIELDS-1:0] src_enabled_o,
	output logic [FIELD_W-1:0] can_a_event_prio_o,
	output logic [FIELD_W-1:0] can_a_receive_prio_o,
	output logic [FIELD_W-1:0] serial_periph_b_event_prio_o,
	output logic [FIELD_W-1:0] serial_periph_b_error_prio_o,
	output logic [FIELD_W-1:0] capture_ch5_prio_o,
	output logic [FIELD_W-1:0] capture_ch4_prio_o,
	output logic [FIELD_W-1:0] capture_ch3_prio_o,
	output logic [FIELD_W-1:0] xfer_ch3_done_prio_o,
	output logic [FIELD_W-1:0] compare_ch7_prio_o,
	output logic [FIELD_W-1:0] compare_ch6_prio_o,
	output logic [FIELD_W-1:0] compare_ch5_prio_o,
	output logic [FIELD_W-1:0] capture_ch6_prio_o,
	output logic [FIELD_W-1:0] timer_six_prio_o,
	output logic [FIELD_W-1:0] xfer_ch4_done_prio_o,
	output logic [FIELD_W-1:0] compare_ch8_prio_o,
	output logic [FIELD_W-1:0] timer_eight_prio_o,
	output logic [FIELD_W-1:0] twowire_b_master_prio_o,
	output logic [FIELD_W-1:0] twowire_b_slave_prio_o,
	output logic [FIELD_W-1:0] timer_seven_prio_o
);

	// Builds the readable image of one register from all field values
	function automatic logic [REG_W-1:0] reg_image(
		input logic [2:0] idx,
		input logic [NUM_FIELDS*FIELD_W-1:0] flat
	);
		logic [REG_W-1:0] img;
		img = '0;
		for (int f = 0; f < NUM_FIELDS; f++) begin
			if (FIELD_REG[f] == int'(idx)) begin
				img[FIELD_LSB[f] +: FIELD_W] = flat[f*FIELD_W +: FIELD_W];
			end
		end
		// RQ4: unimplemented bits zero
		return img & REG_MASK[idx];
	endfunction : reg_image

	logic ack_r;
	logic ack_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic [FIELD_W-1:0] prio_w [NUM_FIELDS];
	logic [NUM_FIELDS*FIELD_W-1:0] prio_flat;
	logic [NUM_FIELDS-1:0] field_wr;

	wire logic bus_req = avs_read_i | avs_write_i;
	wire logic wr_take = avs_write_i & ack_r;
	wire logic rd_start = avs_read_i & ~ack_r;
	wire logic [2:0] reg_sel = avs_address_i[ADDR_W-1:WORD_LSB];
	wire logic reg_hit = (reg_sel < 3'(NUM_REGS));
	wire logic [REG_W-1:0] sel_image = reg_image(reg_sel, prio_flat);

	// One wait state gives the read mux a full cycle
	assign ack_nxt = bus_req & ~ack_r;
	assign avs_waitrequest_o = bus_req & ~ack_r;

	// Unmapped words read zero and drop writes
	assign rdata_nxt = rd_start ? (reg_hit ? {16'h0000, sel_image} : 32'h0000_0000) : rdata_r;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign avs_readdata_o = rdata_r;

	genvar g;
	generate
		for (g = 0; g < NUM_FIELDS; g++) begin : gen_field
			// RQ16: lane-qualified field write
			assign field_wr[g] = wr_take & reg_hit & (int'(reg_sel) == FIELD_REG[g])
				& avs_byteenable_i[FIELD_LSB[g] / BYTE_W];

			ipb_prio_field u_field (
				.clk_i(clk_i),
				.sys_rst_i(sys_rst_i),
				.wr_en_i(field_wr[g]),
				.wr_data_i(avs_writedata_i[FIELD_LSB[g] +: FIELD_W]),
				.prio_o(prio_w[g]),
				.enabled_o(src_enabled_o[g])
			);

			assign prio_flat[g*FIELD_W +: FIELD_W] = prio_w[g];
		end
	endgenerate

	// RQ2: disabled sources masked
	assign src_request_o = src_pending_i & src_enabled_o;

	// RQ6: register 8 high byte
	assign can_a_event_prio_o = prio_w[0];
	assign can_a_receive_prio_o = prio_w[1];
	// RQ7: register 8 low byte
	assign serial_periph_b_event_prio_o = prio_w[2];
	assign serial_periph_b_error_prio_o = prio_w[3];
	// RQ8: register 9 high byte
	assign capture_ch5_prio_o = prio_w[4];
	assign capture_ch4_prio_o = prio_w[5];
	// RQ9: register 9 low byte
	assign capture_ch3_prio_o = prio_w[6];
	assign xfer_ch3_done_prio_o = prio_w[7];
	// RQ10: register 10 high byte
	assign compare_ch7_prio_o = prio_w[8];
	assign compare_ch6_prio_o = prio_w[9];
	// RQ11: register 10 low byte
	assign compare_ch5_prio_o = prio_w[10];
	assign capture_ch6_prio_o = prio_w[11];
	// RQ12: register 11 high byte
	assign timer_six_prio_o = prio_w[12];
	assign xfer_ch4_done_prio_o = prio_w[13];
	// RQ13: register 11 low byte
	assign compare_ch8_prio_o = prio_w[14];
	// RQ14: register 12 high byte
	assign timer_eight_prio_o = prio_w[15];
	assign twowire_b_master_prio_o = prio_w[16];
	// RQ15: register 12 low byte
	assign twowire_b_slave_prio_o = prio_w[17];
	assign timer_seven_prio_o = prio_w[18];

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	wire logic rd_done = avs_read_i & ~avs_waitrequest_o;
	wire logic wr_done = avs_write_i & ~avs_waitrequest_o;

	// Bus answer bound
	wait_bound_a: assert property (
		bus_req && avs_waitrequest_o |=> !avs_waitrequest_o
	) else $error("waitrequest held more than one cycle");

	// RQ5: reset value check
	reset_value_a: assert property ( // RQ5
		$past(sys_rst_i) |-> (prio_flat == {NUM_FIELDS{FIELD_RST}})
	) else $error("field not 100 after reset");

	// RQ1: top level requests
	top_level_a: assert property ( // RQ1
		timer_seven_prio_o == PRIO_MAX && src_pending_i[18] |-> src_request_o[18]
	) else $error("level 7 source not requesting");

	// RQ2: disabled never requests
	off_gated_a: assert property ( // RQ2
		can_a_event_prio_o == PRIO_OFF |-> !src_request_o[0] && !src_enabled_o[0]
	) else $error("disabled source requested");

	// RQ3: lowest level requests
	low_level_a: assert property ( // RQ3
		xfer_ch4_done_prio_o == PRIO_MIN && src_pending_i[13] |-> src_request_o[13]
	) else $error("level 1 source not requesting");

	// RQ4: unused bits read zero
	unused_zero_a: assert property ( // RQ4
		rd_done |-> avs_readdata_o[31:16] == 16'h0000
			&& avs_readdata_o[15] == 1'b0 && avs_readdata_o[11] == 1'b0
			&& avs_readdata_o[7] == 1'b0 && avs_readdata_o[3] == 1'b0
	) else $error("unimplemented bit reads one");

	// RQ6: CAN fields placed
	can_place_a: assert property ( // RQ6
		rd_done && avs_address_i == PRIO_CTRL_8_OFS |->
			avs_readdata_o[14:12] == can_a_event_prio_o
			&& avs_readdata_o[10:8] == can_a_receive_prio_o
	) else $error("CAN field misplaced");

	// RQ7: SPI fields placed
	spi_place_a: assert property ( // RQ7
		rd_done && avs_address_i == PRIO_CTRL_8_OFS |->
			avs_readdata_o[6:4] == serial_periph_b_event_prio_o
			&& avs_readdata_o[2:0] == serial_periph_b_error_prio_o
	) else $error("SPI field misplaced");

	// RQ8: capture high placed
	cap_high_a: assert property ( // RQ8
		rd_done && avs_address_i == PRIO_CTRL_9_OFS |->
			avs_readdata_o[14:12] == capture_ch5_prio_o
			&& avs_readdata_o[10:8] == capture_ch4_prio_o
	) else $error("capture 5/4 misplaced");

	// RQ9: capture low placed
	cap_low_a: assert property ( // RQ9
		rd_done && avs_address_i == PRIO_CTRL_9_OFS |->
			avs_readdata_o[6:4] == capture_ch3_prio_o
			&& avs_readdata_o[2:0] == xfer_ch3_done_prio_o
	) else $error("capture 3 or DMA 3 misplaced");

	// RQ10: compare high placed
	cmp_high_a: assert property ( // RQ10
		rd_done && avs_address_i == PRIO_CTRL_10_OFS |->
			avs_readdata_o[14:12] == compare_ch7_prio_o
			&& avs_readdata_o[10:8] == compare_ch6_prio_o
	) else $error("compare 7/6 misplaced");

	// RQ11: compare low placed
	cmp_low_a: assert property ( // RQ11
		rd_done && avs_address_i == PRIO_CTRL_10_OFS |->
			avs_readdata_o[6:4] == compare_ch5_prio_o
			&& avs_readdata_o[2:0] == capture_ch6_prio_o
	) else $error("compare 5 or capture 6 misplaced");

	// RQ12: timer six placed
	tmr_six_a: assert property ( // RQ12
		rd_done && avs_address_i == PRIO_CTRL_11_OFS |->
			avs_readdata_o[14:12] == timer_six_prio_o
			&& avs_readdata_o[10:8] == xfer_ch4_done_prio_o
	) else $error("timer 6 or DMA 4 misplaced");

	// RQ13: sparse low byte
	sparse_low_a: assert property ( // RQ13
		rd_done && avs_address_i == PRIO_CTRL_11_OFS |->
			avs_readdata_o[7:3] == 5'h00
			&& avs_readdata_o[2:0] == compare_ch8_prio_o
	) else $error("register 11 low byte wrong");

	// RQ14: timer eight placed
	tmr_eight_a: assert property ( // RQ14
		rd_done && avs_address_i == PRIO_CTRL_12_OFS |->
			avs_readdata_o[14:12] == timer_eight_prio_o
			&& avs_readdata_o[10:8] == twowire_b_master_prio_o
	) else $error("timer 8 or I2C master misplaced");

	// RQ15: I2C slave placed
	i2c_slave_a: assert property ( // RQ15
		rd_done && avs_address_i == PRIO_CTRL_12_OFS |->
			avs_readdata_o[6:4] == twowire_b_slave_prio_o
			&& avs_readdata_o[2:0] == timer_seven_prio_o
	) else $error("I2C slave or timer 7 misplaced");

	// RQ16: write lands next edge
	write_lands_a: assert property ( // RQ16
		wr_done && avs_address_i == PRIO_CTRL_12_OFS && avs_byteenable_i[0] |=>
			timer_seven_prio_o == $past(avs_writedata_i[2:0])
			&& twowire_b_slave_prio_o == $past(avs_writedata_i[6:4])
	) else $error("write did not land");

	// RQ16: unselected lane kept
	lane_keep_a: assert property ( // RQ16
		wr_done && avs_address_i == PRIO_CTRL_12_OFS && !avs_byteenable_i[1] |=>
			$stable(timer_eight_prio_o) && $stable(twowire_b_master_prio_o)
	) else $error("disabled lane written");

	// RQ17: readback equals outputs
	image_match_a: assert property ( // RQ17
		rd_start && reg_hit ##1 !wr_done |->
			avs_readdata_o[15:0] == reg_image($past(reg_sel), prio_flat)
	) else $error("read image differs from presented levels");

	// Every request opens with a wait state
	wait_first_a: assert property (
		$rose(bus_req) |-> avs_waitrequest_o
	) else $error("request answered without wait state");

	// Read data stands until the next read loads
	read_hold_a: assert property (
		!rd_start |=> $stable(avs_readdata_o)
	) else $error("read data changed without a read");

	// Unmapped words read zero
	unmapped_zero_a: assert property (
		rd_done && !reg_hit |-> avs_readdata_o == 32'h0000_0000
	) else $error("unmapped word read nonzero");

	// Unmapped writes are dropped
	unmapped_drop_a: assert property (
		wr_done && !reg_hit |=> $stable(prio_flat)
	) else $error("unmapped write changed a field");

	// RQ16: fields move only on writes
	field_quiet_a: assert property ( // RQ16
		!wr_done |=> $stable(prio_flat)
	) else $error("field changed without a write");

	// RQ6: CAN write lands
	can_lands_a: assert property ( // RQ6
		wr_done && avs_address_i == PRIO_CTRL_8_OFS && avs_byteenable_i[1] |=>
			can_a_event_prio_o == $past(avs_writedata_i[14:12])
			&& can_a_receive_prio_o == $past(avs_writedata_i[10:8])
	) else $error("CAN field write did not land");

	// RQ8: capture write lands
	cap_lands_a: assert property ( // RQ8
		wr_done && avs_address_i == PRIO_CTRL_9_OFS && avs_byteenable_i[1] |=>
			capture_ch5_prio_o == $past(avs_writedata_i[14:12])
			&& capture_ch4_prio_o == $past(avs_writedata_i[10:8])
	) else $error("capture field write did not land");

	// RQ13: compare 8 write lands
	cmp8_lands_a: assert property ( // RQ13
		wr_done && avs_address_i == PRIO_CTRL_11_OFS && avs_byteenable_i[0] |=>
			compare_ch8_prio_o == $past(avs_writedata_i[2:0])
	) else $error("compare 8 write did not land");

	// RQ3: enabled levels request
	mid_level_a: assert property ( // RQ3
		twowire_b_master_prio_o != PRIO_OFF && src_pending_i[16] |-> src_request_o[16]
	) else $error("enabled source not requesting");

	// RQ3: nonzero code enables
	enable_on_a: assert property ( // RQ3
		timer_seven_prio_o != PRIO_OFF |-> src_enabled_o[18]
	) else $error("nonzero level reported disabled");

	// RQ17: request needs pending source
	request_gate_a: assert property ( // RQ17
		(src_request_o & ~src_pending_i) == '0
	) else $error("request without pending source");

endmodule : ipb_prio_bank

// ==== src/ipb_pkg.sv ====
package ipb_pkg;

	// Bank geometry
	localparam int NUM_FIELDS = 19;
	localparam int NUM_REGS = 5;
	localparam int FIELD_W = 3;
	localparam int REG_W = 16;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 5;
	localparam int BYTE_W = 8;

	// Byte offsets of the priority registers
	localparam logic [ADDR_W-1:0] PRIO_CTRL_8_OFS = 5'h00;
	localparam logic [ADDR_W-1:0] PRIO_CTRL_9_OFS = 5'h04;
	localparam logic [ADDR_W-1:0] PRIO_CTRL_10_OFS = 5'h08;
	localparam logic [ADDR_W-1:0] PRIO_CTRL_11_OFS = 5'h0C;
	localparam logic [ADDR_W-1:0] PRIO_CTRL_12_OFS = 5'h10;
	localparam int WORD_LSB = 2;

	// Field values
	localparam logic [FIELD_W-1:0] FIELD_RST = 3'h4;
	localparam logic [FIELD_W-1:0] PRIO_OFF = 3'h0;
	localparam logic [FIELD_W-1:0] PRIO_MIN = 3'h1;
	localparam logic [FIELD_W-1:0] PRIO_MAX = 3'h7;

	// Field positions
	localparam int LSB_HI = 12;
	localparam int LSB_MH = 8;
	localparam int LSB_ML = 4;
	localparam int LSB_LO = 0;

	// Register index and low bit of every field, in port order
	localparam int FIELD_REG [NUM_FIELDS] = '{
		0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 4, 4, 4, 4};
	localparam int FIELD_LSB [NUM_FIELDS] = '{
		12, 8, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0, 12, 8, 0, 12, 8, 4, 0};

	// Implemented bits of each register
	localparam logic [REG_W-1:0] REG_MASK [NUM_REGS] = '{
		16'h7777, 16'h7777, 16'h7777, 16'h7707, 16'h7777};

endpackage : ipb_pkg

// ==== src/ipb_prio_field.sv ====
`timescale 1ns/1ns
module ipb_prio_field
	import ipb_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic wr_en_i,
	input wire logic [FIELD_W-1:0] wr_data_i,
	output logic [FIELD_W-1:0] prio_o,
	output logic enabled_o
);

	logic [FIELD_W-1:0] prio_r;
	logic [FIELD_W-1:0] prio_nxt;

	// RQ16: new value on write
	assign prio_nxt = wr_en_i ? wr_data_i : prio_r;

	always_ff @(posedge clk_i) begin
		// RQ5: reset to level four
		if (sys_rst_i) begin
			prio_r <= FIELD_RST;
		end else begin
			prio_r <= prio_nxt;
		end
	end

	// RQ17: level always visible
	assign prio_o = prio_r;
	// RQ2: zero means disabled
	assign enabled_o = (prio_r != PRIO_OFF);

endmodule : ipb_prio_field

// ==== tb/interrupt_priority_bank_8_to_12_tb.sv ====
`timescale 1ns/1ns
module interrupt_priority_bank_8_to_12_tb
	import ipb_pkg::*;
;
	typedef struct packed {
		logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] d;
		logic [3:0] be;
		logic [DATA_W-1:0] e;
	} ipb_row_t;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [ADDR_W-1:0] avs_address_i = '0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [DATA_W-1:0] avs_writedata_i = '0;
	logic [DATA_W/BYTE_W-1:0] avs_byteenable_i = '0;
	logic [NUM_FIELDS-1:0] src_pending_i = '0;
	logic [DATA_W-1:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [NUM_FIELDS-1:0] src_request_o;
	logic [NUM_FIELDS-1:0] src_enabled_o;
	logic [NUM_FIELDS*FIELD_W-1:0] pf;
	int fails = 0;
	int cmp_count = 0;
	ipb_row_t rows [9] = '{
		'{5'h00, 32'hFFFFFFFF, 4'hF, 32'h00007777},
		'{5'h0C, 32'hFFFFFFFF, 4'hF, 32'h00007707},
		'{5'h04, 32'h00000000, 4'hF, 32'h00000000},
		'{5'h08, 32'h00001111, 4'hF, 32'h00001111},
		'{5'h10, 32'h00005555, 4'h1, 32'h00004455},
		'{5'h10, 32'h00007300, 4'h2, 32'h00007355},
		'{5'h14, 32'h0000FFFF, 4'hF, 32'h00000000},
		'{5'h1C, 32'h0000FFFF, 4'hF, 32'h00000000},
		'{5'h00, 32'h00006543, 4'hF, 32'h00006543}};
	logic [FIELD_W-1:0] map_exp [NUM_FIELDS] = '{
		3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1, 3'h2, 3'h3,
		3'h4, 3'h5, 3'h6, 3'h7, 3'h5, 3'h3, 3'h4, 3'h5, 3'h6};
	logic [DATA_W-1:0] map_wr [NUM_REGS] = '{
		32'h00001234, 32'h00005671, 32'h00002345, 32'h00006705, 32'h00003456};
	logic [DATA_W-1:0] q;
	logic [FIELD_W-1:0] c;

	ipb_prio_bank uut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.src_pending_i(src_pending_i), .src_request_o(src_request_o),
		.src_enabled_o(src_enabled_o),
		.can_a_event_prio_o(pf[2:0]), .can_a_receive_prio_o(pf[5:3]),
		.serial_periph_b_event_prio_o(pf[8:6]), .serial_periph_b_error_prio_o(pf[11:9]),
		.capture_ch5_prio_o(pf[14:12]), .capture_ch4_prio_o(pf[17:15]),
		.capture_ch3_prio_o(pf[20:18]), .xfer_ch3_done_prio_o(pf[23:21]),
		.compare_ch7_prio_o(pf[26:24]), .compare_ch6_prio_o(pf[29:27]),
		.compare_ch5_prio_o(pf[32:30]), .capture_ch6_prio_o(pf[35:33]),
		.timer_six_prio_o(pf[38:36]), .xfer_ch4_done_prio_o(pf[41:39]),
		.compare_ch8_prio_o(pf[44:42]), .timer_eight_prio_o(pf[47:45]),
		.twowire_b_master_prio_o(pf[50:48]), .twowire_b_slave_prio_o(pf[53:51]),
		.timer_seven_prio_o(pf[56:54])
	);

	initial begin
		forever #4 clk_i = ~clk_i;
	end

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Request held until waitrequest is sampled low; bounded wait
	task automatic bus(input logic [ADDR_W-1:0] a, input logic wr, input logic [DATA_W-1:0] d,
			input logic [3:0] be);
		int n;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		avs_writedata_i <= d;
		avs_byteenable_i <= be;
		for (n = 0; n < 20; n++) begin
			@(posedge clk_i);
			if (avs_waitrequest_o === 1'b0) break;
		end
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (n == 20) begin
			fails++;
			$display("BAD at %0t: bus request never completed", $time);
			stop_test();
		end
		#1;
	endtask : bus

	// Every field output equal to one code
	task automatic chk_all(input logic [FIELD_W-1:0] v);
		for (int i = 0; i < NUM_FIELDS; i++) chk(pf[i*FIELD_W+:FIELD_W], v);
	endtask : chk_all

	initial begin
		repeat (8) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		#1;
		chk_all(FIELD_RST);
		for (int r = 0; r < NUM_REGS; r++) begin
			bus(5'(r * 4), 1'b0, '0, 4'hF);
			chk(q, {16'h0000, REG_MASK[r] & 16'h4444});
		end
		// Register, partial byte-lane and unmapped-word cases: write, then read back
		foreach (rows[i]) begin
			bus(rows[i].a, 1'b1, rows[i].d, rows[i].be);
			bus(rows[i].a, 1'b0, '0, 4'hF);
			chk(q, rows[i].e);
		end
		for (int r = 0; r < NUM_REGS; r++) bus(5'(r * 4), 1'b1, map_wr[r], 4'hF);
		for (int i = 0; i < NUM_FIELDS; i++) chk(pf[i*FIELD_W+:FIELD_W], map_exp[i]);
		// Every code in every field, with gating of pending sources
		for (int k = 0; k < 8; k++) begin
			c = 3'(k);
			@(posedge clk_i);
			src_pending_i <= (k % 2 == 1) ? 19'h5A5A5 : 19'h7FFFF;
			for (int r = 0; r < NUM_REGS; r++) bus(5'(r * 4), 1'b1, {8{1'b0, c}}, 4'hF);
			chk_all(c);
			chk(32'(src_enabled_o), (c == PRIO_OFF) ? 32'h0 : 32'h7FFFF);
			chk(32'(src_request_o), (c == PRIO_OFF) ? 32'h0 : 32'(src_pending_i));
		end
		// Second reset in mid-run restores the defaults
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		@(posedge clk_i);
		sys_rst_i <= 1'b0;
		#1;
		chk_all(FIELD_RST);
		bus(PRIO_CTRL_11_OFS, 1'b0, '0, 4'hF);
		chk(q, 32'h00004404);
		stop_test();
	end

	initial begin
		#80000;
		fails++;
		$display("BAD at %0t: run limit reached", $time);
		stop_test();
	end
endmodule : interrupt_priority_bank_8_to_12_tb
